// File: verilog/rsc_defs.svh
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// Clock period in ns and timing figures in input clock periods.
`define RSC_CLK_PERIOD_NS 20
`define RSC_FILTER_CYCLES 4
`define RSC_LATCH_CYCLE 5
`define RSC_STRETCH_CYCLES 18
`define RSC_FETCH_DELAY_MIN 5
`define RSC_FETCH_DELAY_MAX 10
`define RSC_FETCH_DELAY 8'h07
`define RSC_OSC_START_CYCLES 5
`define RSC_POR_CYCLES_DEFAULT 64
`define RSC_RESET_VECTOR 16'h000c
// Register map, byte addresses.
`define RSC_OFF_CTRL 8'h00
`define RSC_OFF_STATUS 8'h04
`define RSC_OFF_KEPT 8'h08
`define RSC_OFF_BUSMODE 8'h0c
// Control register fields.
`define RSC_CTRL_HALT_BIT 0
`define RSC_CTRL_RUN_BIT 1
`define RSC_CTRL_DSPRST_BIT 2
`define RSC_CTRL_DELAYSEL_BIT 3
// Bus mode register fields.
`define RSC_BM_EXT_TIMING_BIT 0
`define RSC_BM_P0_ADDR_BIT 1
// Kept register layout: watchdog control, stop recovery, port2, port3 modes.
`define RSC_KEPT_RESET 32'h0000_0000
`endif

// File: verilog/rsc_pkg.sv
package rsc_pkg;
  typedef enum logic [1:0] {RSC_IDLE, RSC_FILTER, RSC_HOLD, RSC_FETCH} rsc_phase_e;
  typedef enum logic [1:0] {RSC_DSP_RUN, RSC_DSP_HALT, RSC_DSP_RESET} rsc_dsp_e;
  typedef struct packed {
    logic por;
    logic watchdog;
    logic stop_recovery;
    logic pin;
  } rsc_cause_s;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } rsc_ahb_req_s;
endpackage : rsc_pkg

// File: verilog/rsc_pin_filter.sv
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_pin_filter (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pin side.
  input wire logic pin_n,
  // Filtered result.
  output logic low_valid,
  output logic low_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [2:0] cnt;
    logic valid;
  } rsc_flt_s;
  rsc_flt_s st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_n;
    st_nxt.s2 = st_r.s1;
    st_nxt.valid = 1'b0;
    if (st_r.s2) begin
      st_nxt.cnt = 3'h0;
    end else if (st_r.cnt != 3'(`RSC_FILTER_CYCLES)) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
    // A low shorter than the filter window never reaches the counter limit.
    if (!st_r.s2 && st_r.cnt == 3'(`RSC_FILTER_CYCLES - 1)) begin
      st_nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 3'h0, valid: 1'b0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign low_valid = st_r.valid;
  assign low_level = !st_r.s2;
endmodule : rsc_pin_filter

// File: verilog/rsc_reset_startup_control.sv
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_reset_startup_control
  import rsc_pkg::*;
#(
  parameter int POR_CYCLES = `RSC_POR_CYCLES_DEFAULT
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset sources.
  input wire logic por_event,
  input wire logic watchdog_timeout,
  input wire logic stop_recovery_event,
  // Open-drain reset pin.
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Mode strap.
  input wire logic rom_disable_pin,
  // Processor controls.
  output logic cpu_reset,
  output logic cpu_fetch_start,
  output logic [15:0] cpu_fetch_addr,
  output logic dsp_reset,
  output logic dsp_halt,
  output logic internal_rom_enable,
  output logic port0_addr_mode,
  output logic [7:0] port0_dir_input,
  output logic ext_timing
);
  typedef struct packed {
    rsc_phase_e phase;
    logic [4:0] hold_cnt;
    logic [7:0] fetch_cnt;
    logic [15:0] por_cnt;
    logic por_drive;
    logic stop_cause;
    logic pin_cause;
    rsc_dsp_e dsp;
    logic delay_sel;
    logic [31:0] kept;
    logic ext_timing;
    logic p0_addr;
    logic rom_dis1;
    logic rom_dis2;
    logic rom_mode;
    rsc_cause_s last_cause;
    logic cpu_rst;
    logic dsp_rst;
    logic fetch;
    logic bus_act;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] rdata;
  } rsc_state_s;
  rsc_state_s st_r, st_nxt;
  logic pin_valid;
  logic pin_low;
  logic por_or_wdt;
  logic addr_phase;

  // The pin filter holds its own two-flop synchroniser.
  rsc_pin_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_n(reset_pin_in),
    .low_valid(pin_valid),
    .low_level(pin_low)
  );

  assign por_or_wdt = por_event || watchdog_timeout;
  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    st_nxt = st_r;
    st_nxt.fetch = 1'b0;
    st_nxt.rom_dis1 = rom_disable_pin;
    st_nxt.rom_dis2 = st_r.rom_dis1;
    // Power-on interval counter drives the pin low while it runs.
    if (por_or_wdt) begin
      st_nxt.por_cnt = 16'(POR_CYCLES);
      st_nxt.por_drive = 1'b1;
    end else if (st_r.por_cnt != 16'h0000) begin
      st_nxt.por_cnt = st_r.por_cnt - 16'h0001;
    end else begin
      st_nxt.por_drive = 1'b0;
    end
    unique case (st_r.phase)
      RSC_IDLE, RSC_FETCH: begin
        if (st_r.phase == RSC_FETCH) begin
          if (st_r.fetch_cnt == 8'h00) begin
            st_nxt.fetch = 1'b1;
            st_nxt.cpu_rst = 1'b0;
            st_nxt.phase = RSC_IDLE;
          end else begin
            st_nxt.fetch_cnt = st_r.fetch_cnt - 8'h01;
          end
        end
        // Any of four sources starts a reset.
        if (por_or_wdt || stop_recovery_event || pin_valid) begin
          st_nxt.phase = RSC_FILTER;
          st_nxt.hold_cnt = 5'h00;
          st_nxt.stop_cause = stop_recovery_event && !por_or_wdt && !pin_valid;
          st_nxt.pin_cause = pin_valid;
          st_nxt.last_cause = '{por: por_event, watchdog: watchdog_timeout,
                                stop_recovery: stop_recovery_event, pin: pin_valid};
        end
      end
      RSC_FILTER: begin
        // The latch sets on the fifth clock after detection.
        st_nxt.hold_cnt = st_r.hold_cnt + 5'h01;
        if (st_r.hold_cnt == 5'(`RSC_LATCH_CYCLE - 2)) begin
          st_nxt.phase = RSC_HOLD;
          st_nxt.hold_cnt = 5'h00;
          st_nxt.cpu_rst = 1'b1;
          // Pin and power-on resets also reset the signal processor.
          if (st_r.pin_cause || st_r.last_cause.por) begin
            st_nxt.dsp_rst = 1'b1;
            st_nxt.dsp = RSC_DSP_RUN;
          end
          if (!st_r.stop_cause) begin
            // Stop recovery leaves the kept mode registers alone.
            st_nxt.kept = `RSC_KEPT_RESET;
            st_nxt.delay_sel = 1'b0;
          end
          // Strap sampled at reset sets port 0 and bus timing.
          st_nxt.rom_mode = !st_r.rom_dis2;
          st_nxt.ext_timing = st_r.rom_dis2;
          st_nxt.p0_addr = st_r.rom_dis2;
        end
      end
      RSC_HOLD: begin
        // Hold 18 clocks or while the pin stays low, whichever is longer.
        if (st_r.hold_cnt != 5'(`RSC_STRETCH_CYCLES)) begin
          st_nxt.hold_cnt = st_r.hold_cnt + 5'h01;
        end else if (!pin_low && !st_r.por_drive) begin
          st_nxt.phase = RSC_FETCH;
          st_nxt.dsp_rst = 1'b0;
          // After stop recovery, a zero delay select adds oscillator start-up time.
          st_nxt.fetch_cnt = `RSC_FETCH_DELAY;
          if (st_r.stop_cause && !st_r.delay_sel) begin
            st_nxt.fetch_cnt = 8'(`RSC_FETCH_DELAY_MAX - 2);
          end
        end
      end
    endcase
    // Bus data phase. Commands from the control processor steer the DSP.
    if (st_r.bus_act && st_r.bus_wr) begin
      unique case (st_r.bus_addr)
        `RSC_OFF_CTRL: begin
          st_nxt.delay_sel = hwdata[`RSC_CTRL_DELAYSEL_BIT];
          if (hwdata[`RSC_CTRL_DSPRST_BIT]) begin
            st_nxt.dsp = RSC_DSP_RESET;
          end else if (hwdata[`RSC_CTRL_HALT_BIT]) begin
            st_nxt.dsp = RSC_DSP_HALT;
          end else if (hwdata[`RSC_CTRL_RUN_BIT]) begin
            st_nxt.dsp = RSC_DSP_RUN;
          end
        end
        `RSC_OFF_KEPT: st_nxt.kept = hwdata;
        // Software may drop extended timing after ROMless start.
        `RSC_OFF_BUSMODE: begin
          st_nxt.ext_timing = hwdata[`RSC_BM_EXT_TIMING_BIT];
          st_nxt.p0_addr = hwdata[`RSC_BM_P0_ADDR_BIT];
        end
        default: ;
      endcase
    end
    // Watchdog and stop recovery never move a halted DSP back to run.
    st_nxt.bus_act = addr_phase;
    st_nxt.bus_wr = hwrite;
    st_nxt.bus_addr = haddr[7:0];
    st_nxt.rdata = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `RSC_OFF_CTRL: st_nxt.rdata = {28'h0000000, st_r.delay_sel,
                                       st_r.dsp == RSC_DSP_RESET, 1'b0,
                                       st_r.dsp == RSC_DSP_HALT};
        `RSC_OFF_STATUS: st_nxt.rdata = {24'h000000, st_r.rom_mode, st_r.por_drive,
                                         st_r.phase, st_r.last_cause};
        `RSC_OFF_KEPT: st_nxt.rdata = st_r.kept;
        `RSC_OFF_BUSMODE: st_nxt.rdata = {30'h00000000, st_r.p0_addr, st_r.ext_timing};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Output flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cpu_reset <= 1'b1;
      cpu_fetch_start <= 1'b0;
      cpu_fetch_addr <= `RSC_RESET_VECTOR;
      dsp_reset <= 1'b1;
      dsp_halt <= 1'b0;
      internal_rom_enable <= 1'b1;
      port0_addr_mode <= 1'b0;
      port0_dir_input <= 8'hff;
      ext_timing <= 1'b0;
    end else if (clk_en) begin
      reset_pin_oe <= st_nxt.por_drive;
      // Reset stays up through the fetch delay, so a new source there cannot glitch it, except in its last cycle, where reset falls and the fetch starts anyway.
      cpu_reset <= st_nxt.cpu_rst;
      cpu_fetch_start <= st_nxt.fetch;
      dsp_reset <= st_nxt.dsp_rst || st_nxt.dsp == RSC_DSP_RESET;
      dsp_halt <= st_nxt.dsp == RSC_DSP_HALT;
      internal_rom_enable <= !st_r.rom_dis2;
      port0_addr_mode <= st_nxt.p0_addr;
      port0_dir_input <= st_nxt.p0_addr ? 8'h00 : 8'hff;
      ext_timing <= st_nxt.ext_timing;
    end
  end

  assign hrdata = st_r.rdata;
endmodule : rsc_reset_startup_control

// File: dv/rsc_ext_reset_model.sv
`timescale 1ns/1ps
module rsc_ext_reset_model (
  // Far side request.
  input wire logic pull_low,
  // Device pin driver.
  input wire logic dut_oe,
  input wire logic dut_out,
  // Shared line.
  output logic line
);
  // The line has a pull-up, so it rests high unless some party sinks it.
  assign line = (pull_low || (dut_oe && !dut_out)) ? 1'b0 : 1'b1;
endmodule : rsc_ext_reset_model

// File: dv/rsc_reset_startup_control_props.sv
`timescale 1ns/1ps
module rsc_chk #(
  parameter int POR_CYCLES = 64
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Sources, pin and strap.
  input wire logic por_event,
  input wire logic watchdog_timeout,
  input wire logic stop_recovery_event,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic rom_disable_pin,
  input wire logic hsel,
  // Processor controls.
  input wire logic cpu_reset,
  input wire logic cpu_fetch_start,
  input wire logic [15:0] cpu_fetch_addr,
  input wire logic dsp_reset,
  input wire logic dsp_halt,
  input wire logic internal_rom_enable,
  input wire logic port0_addr_mode,
  input wire logic [7:0] port0_dir_input
);
  localparam int POR_MIN = POR_CYCLES - 1;
  logic [7:0] hold_cnt_r;
  logic [7:0] oe_cnt_r;
  // Reset loads the top so that the drop just after reset is not judged.
  always_ff @(posedge clk) begin
    if (sys_rst) hold_cnt_r <= 8'hff;
    else if (!cpu_reset) hold_cnt_r <= 8'h00;
    else if (hold_cnt_r != 8'hff) hold_cnt_r <= hold_cnt_r + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || !reset_pin_oe) oe_cnt_r <= 8'h00;
    else if (oe_cnt_r != 8'hff) oe_cnt_r <= oe_cnt_r + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_short_pulse;
    !cpu_reset && $fell(reset_pin_in) ##1 !reset_pin_in ##1 !reset_pin_in ##1 reset_pin_in
      |-> !cpu_reset [*8];
  endproperty
  property p_stretch;
    $fell(cpu_reset) |-> hold_cnt_r >= 8'h12;
  endproperty
  property p_fetch;
    cpu_fetch_start |-> cpu_fetch_addr == 16'h000c ##1 !cpu_fetch_start;
  endproperty
  property p_drive;
    (por_event || watchdog_timeout) && !cpu_reset |-> ##[1:3] reset_pin_oe;
  endproperty
  property p_drive_len;
    $fell(reset_pin_oe) |-> oe_cnt_r >= POR_MIN;
  endproperty
  property p_pin_dsp;
    !reset_pin_in && !reset_pin_oe && cpu_reset |-> ##[0:2] dsp_reset;
  endproperty
  property p_halt_kept;
    dsp_halt && stop_recovery_event && !hsel |=> dsp_halt [*8];
  endproperty
  property p_strap;
    $stable(rom_disable_pin) [*6] |-> internal_rom_enable != rom_disable_pin;
  endproperty
  property p_port0;
    cpu_fetch_start |-> port0_dir_input == (internal_rom_enable ? 8'hff : 8'h00)
      && port0_addr_mode == !internal_rom_enable;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pin low reset");
  a_stretch: assert property (p_stretch) else $error("internal reset too short");
  a_fetch: assert property (p_fetch) else $error("bad fetch start");
  a_drive: assert property (p_drive) else $error("pin not driven");
  a_drive_len: assert property (p_drive_len) else $error("pin drive too short");
  a_pin_dsp: assert property (p_pin_dsp) else $error("dsp not reset by pin");
  a_halt_kept: assert property (p_halt_kept) else $error("halted dsp woken");
  a_strap: assert property (p_strap) else $error("rom enable wrong");
  a_port0: assert property (p_port0) else $error("port0 mode wrong");
  c_fetch: cover property (cpu_fetch_start);
  c_drive: cover property ($rose(reset_pin_oe));
  c_halt: cover property (dsp_halt && stop_recovery_event);
endmodule : rsc_chk
bind rsc_reset_startup_control rsc_chk #(.POR_CYCLES(POR_CYCLES)) i_chk (.clk(clk),
  .sys_rst(sys_rst), .por_event(por_event), .watchdog_timeout(watchdog_timeout),
  .stop_recovery_event(stop_recovery_event), .reset_pin_in(reset_pin_in),
  .reset_pin_oe(reset_pin_oe), .rom_disable_pin(rom_disable_pin), .hsel(hsel),
  .cpu_reset(cpu_reset), .cpu_fetch_start(cpu_fetch_start), .cpu_fetch_addr(cpu_fetch_addr),
  .dsp_reset(dsp_reset), .dsp_halt(dsp_halt), .internal_rom_enable(internal_rom_enable),
  .port0_addr_mode(port0_addr_mode), .port0_dir_input(port0_dir_input));

// File: dv/tb_reset_startup_control.sv
`timescale 1ns/1ps
module tb_reset_startup_control;
  logic clk, sys_rst, hsel, hwrite, pull_low, por_event, watchdog_timeout;
  logic stop_recovery_event, rom_disable_pin, hreadyout, line, oe, pout, cpu_reset, fetch;
  logic dsp_reset, dsp_halt, rom_en, p0_mode, ext_timing, dp_rd, hresp, clk_en;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] fetch_addr;
  logic [7:0] p0_dir;
  logic [31:0] exp_q[$];
  int fails, total_checks;
  rsc_reset_startup_control #(.POR_CYCLES(8)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .por_event(por_event),
    .watchdog_timeout(watchdog_timeout), .stop_recovery_event(stop_recovery_event),
    .reset_pin_in(line), .reset_pin_out(pout), .reset_pin_oe(oe),
    .rom_disable_pin(rom_disable_pin), .cpu_reset(cpu_reset), .cpu_fetch_start(fetch),
    .cpu_fetch_addr(fetch_addr), .dsp_reset(dsp_reset), .dsp_halt(dsp_halt),
    .internal_rom_enable(rom_en), .port0_addr_mode(p0_mode), .port0_dir_input(p0_dir),
    .ext_timing(ext_timing));
  rsc_ext_reset_model i_pin (.pull_low(pull_low), .dut_oe(oe), .dut_out(pout), .line(line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task final_report;
    if (exp_q.size() != 0) fails++;
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Read expectations wait in the queue until the data phase shows up.
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    if (!w) exp_q.push_back(d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    for (int k = 0; k < 2; k++) begin
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
        fails++;
        final_report();
      end
      if (k == 0) begin
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
      end
    end
  endtask : bus
  task wait_fetch;
    int i;
    i = 0;
    while (fetch !== 1'b1 && i < 300) begin
      @(posedge clk);
      i++;
    end
    if (i >= 300) begin
      fails++;
      final_report();
    end
  endtask : wait_fetch
  // Read data is taken at the edge that closes the data phase.
  always @(posedge clk) begin
    if (dp_rd === 1'b1) begin
      chk("hrdata", hrdata, exp_q.pop_front());
      chk("hresp", 32'(hresp), 32'h0);
    end
    dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    {sys_rst, hsel, hwrite, pull_low, por_event, watchdog_timeout} = 6'h20;
    {stop_recovery_event, rom_disable_pin, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    clk_en = 1'b1;
    fails = 0;
    total_checks = 0;
    rnd = $urandom(32'h8010);
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    por_event <= 1'b1;
    cyc(1);
    por_event <= 1'b0;
    cyc(2);
    chk("line", 32'(line), 32'h0);
    wait_fetch();
    chk("fetch_addr", 32'(fetch_addr), 32'h000c);
    cyc(2);
    chk("dsp", 32'({dsp_halt, dsp_reset}), 32'h0);
    chk("p0_dir", 32'(p0_dir), 32'hff);
    chk("rom_en", 32'(rom_en), 32'h1);
    for (int n = 1; n < 4; n++) begin
      pull_low <= 1'b1;
      cyc(n);
      pull_low <= 1'b0;
      cyc(14);
      chk("cpu_reset", 32'(cpu_reset), 32'h0);
    end
    rnd = $urandom;
    bus(8'h08, 1'b1, rnd);
    bus(8'h00, 1'b1, 32'h1);
    cyc(3);
    chk("halt", 32'(dsp_halt), 32'h1);
    bus(8'h00, 1'b0, 32'h1);
    stop_recovery_event <= 1'b1;
    cyc(1);
    stop_recovery_event <= 1'b0;
    wait_fetch();
    cyc(2);
    chk("halt", 32'(dsp_halt), 32'h1);
    bus(8'h08, 1'b0, rnd);
    bus(8'h00, 1'b1, 32'h4);
    cyc(3);
    chk("dsp_reset", 32'(dsp_reset), 32'h1);
    bus(8'h00, 1'b1, 32'h2);
    cyc(3);
    chk("dsp", 32'({dsp_halt, dsp_reset}), 32'h0);
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    cyc(2);
    chk("oe", 32'(oe), 32'h1);
    wait_fetch();
    cyc(2);
    pull_low <= 1'b1;
    cyc(25);
    chk("cpu_dsp_reset", 32'({cpu_reset, dsp_reset}), 32'h3);
    pull_low <= 1'b0;
    wait_fetch();
    rom_disable_pin <= 1'b1;
    sys_rst <= 1'b1;
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    pull_low <= 1'b1;
    cyc(10);
    pull_low <= 1'b0;
    wait_fetch();
    cyc(2);
    chk("rom_en", 32'(rom_en), 32'h0);
    chk("romless", 32'({p0_dir, p0_mode, ext_timing}), 32'h3);
    bus(8'h0c, 1'b0, 32'h3);
    bus(8'h0c, 1'b1, 32'h0);
    bus(8'h0c, 1'b0, 32'h0);
    bus(8'h40, 1'b0, 32'h0);
    cyc(3);
    chk("ext_timing", 32'(ext_timing), 32'h0);
    // With the enable low the write must not land.
    clk_en <= 1'b0;
    bus(8'h0c, 1'b1, 32'h1);
    cyc(2);
    chk("frozen_ext_timing", 32'(ext_timing), 32'h0);
    clk_en <= 1'b1;
    cyc(2);
    final_report();
  end
endmodule : tb_reset_startup_control
